// >>> hdl/scs_pkg.sv
// Constants, field layouts and carrier types for the pin and clock select block
package scs_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int PORT_A_PADS = 6;
   localparam int PORT_B_PADS = 8;
   localparam int NUM_PADS = PORT_A_PADS + PORT_B_PADS;
   localparam int CLK_PADS = 4;

   // Register indices; byte address is four times the index
   localparam int REG_IDX_CLOCK_OUT_SELECT = 32'h0a;
   localparam int REG_IDX_PIN_FUNCTION_SELECT = 32'h0b;
   localparam int REG_IDX_PERIPHERAL_CLOCK_GATE = 32'h0c;
   localparam logic [ADDR_W-1:0] ADDR_CLOCK_OUT_SELECT = ADDR_W'(REG_IDX_CLOCK_OUT_SELECT * 4);
   localparam logic [ADDR_W-1:0] ADDR_PIN_FUNCTION_SELECT = ADDR_W'(REG_IDX_PIN_FUNCTION_SELECT * 4);
   localparam logic [ADDR_W-1:0] ADDR_PERIPHERAL_CLOCK_GATE = ADDR_W'(REG_IDX_PERIPHERAL_CLOCK_GATE * 4);

   // Reset values and implemented-bit masks
   localparam logic [REG_W-1:0] CO_RESET = 16'h0020;
   localparam logic [REG_W-1:0] CO_MASK = 16'h03ff;
   localparam logic [REG_W-1:0] GPS_RESET = 16'h0000;
   localparam logic [REG_W-1:0] GPS_MASK = 16'hcfff;
   localparam logic [REG_W-1:0] PCE_RESET = 16'h0000;
   localparam logic [REG_W-1:0] PCE_MASK = 16'ha055;

   // Clock-out select fields
   localparam int CO_SRC_LSB = 0;
   localparam int CO_SRC_W = 5;
   localparam int CO_DIS_BIT = 5;
   localparam int CO_PADSEL_LSB = 6;
   localparam logic [CO_SRC_W-1:0] SRC_SYS = 5'h00;
   localparam logic [CO_SRC_W-1:0] SRC_MASTER_OSCILLATOR_CLOCK = 5'h09;
   localparam logic [CO_SRC_W-1:0] SRC_ADC = 5'h0b;
   localparam logic [CO_SRC_W-1:0] SRC_TCK = 5'h0c;
   localparam logic [CO_SRC_W-1:0] SRC_PER = 5'h0d;
   localparam logic [CO_SRC_W-1:0] SRC_PER_INV = 5'h0e;
   localparam logic [CO_SRC_W-1:0] SRC_HS_PER = 5'h0f;

   // Pin function select fields
   localparam int GPS_TCR_BIT = 15;
   localparam int GPS_PCR_BIT = 14;
   localparam int GPS_B_LSB = 4;
   localparam int GPS_A4_LSB = 0;
   localparam int GPS_A5_LSB = 2;
   localparam logic [1:0] A_FN_FAULT = 2'h2;
   localparam logic [1:0] A_FN_TIMER = 2'h3;

   // Clock gate bits
   localparam int PCE_I2C_BIT = 15;
   localparam int PCE_ADC_BIT = 13;
   localparam int PCE_TMR_BIT = 6;
   localparam int PCE_SCI_BIT = 4;
   localparam int PCE_SPI_BIT = 2;
   localparam int PCE_PWM_BIT = 0;

   // Peripheral signal indices
   localparam int SIG_PIN_A0_CLOCK_SELECT = 0;
   localparam int SIG_PWM4 = 4;
   localparam int SIG_PWM5 = 5;
   localparam int SIG_T0 = 6;
   localparam int SIG_T1 = 7;
   localparam int SIG_T2 = 8;
   localparam int SIG_T3 = 9;
   localparam int SIG_TXD = 10;
   localparam int SIG_RXD = 11;
   localparam int SIG_SCL = 12;
   localparam int SIG_SDA = 13;
   localparam int SIG_MOSI = 14;
   localparam int SIG_MISO = 15;
   localparam int SIG_SS = 16;
   localparam int SIG_SCLK = 17;
   localparam int SIG_PWM_FAULT_INPUT_1 = 18;
   localparam int SIG_PWM_FAULT_INPUT_2 = 19;
   localparam int SIG_PWM_FAULT_INPUT_3 = 20;
   localparam int SIG_CLOCK_OUT_PIN = 21;
   localparam int SIG_COUNT = 22;

   typedef struct packed {
      logic relax;
      logic sys;
      logic sys2x;
      logic sys3x;
      logic master_oscillator_clock;
      logic adc;
      logic tck;
      logic per;
      logic hs_per;
   } scs_clk_src_t;

   typedef struct packed {
      logic i2c;
      logic adc;
      logic tmr;
      logic serial_port_clock_enable;
      logic spi;
      logic pwm;
   } scs_clk_gate_t;

endpackage

// >>> hdl/scs_pin_clock_select.sv
// Pin function routing, clock-out selection, rate selects and clock gates
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Low port-A pins pick PWM or clock
// RULE2: GPIO enable overrides the PWM/clock choice
// RULE3: Reset leaves low port-A pins on PWM
// RULE4: Clock-out disable forces clock pin low
// RULE5: Five-bit field picks clock-out source
// RULE6: Clock-out path is test-only, glitches allowed
// RULE7: Pad peripheral enable has final control
// RULE8: Timer rate bit selects 1x or 3x
// RULE9: PWM rate bit selects 1x or 3x
// RULE10: Change rates only with clock gated off
// RULE11: Use 3x only with PLL running
// RULE12: No 3x PWM with 1x timer reload
// RULE13: Pins B7/B6 pick serial or I2C
// RULE14: Pins B5/B4 pick timer, fault, clock-out
// RULE15: Pins B3/B2 pick SPI or timer
// RULE16: Pins B1/B0 pick SPI or I2C
// RULE17: Pin A5 picks PWM5, pwm_fault_input_2, timer3
// RULE18: Pin A4 picks PWM4, pwm_fault_input_1, timer2
// RULE19: Shared outputs drive both, inputs ORed
// RULE20: Clock-enable bits gate each peripheral clock
// RULE21: Disable peripheral before gating its clock
// RULE22: Reserved bits read zero, ignore writes
// RULE23: Outputs follow stored register next cycle
module scs_pin_clock_select
   import scs_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [DATA_W-1:0] PWDATA,
   output logic [DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Clock sources
   input wire scs_clk_src_t CLK_SRC,
   // GPIO peripheral enables
   input wire logic [PORT_A_PADS-1:0] PORT_A_PERIPHERAL_ENABLE,
   input wire logic [PORT_B_PADS-1:0] PORT_B_PERIPHERAL_ENABLE,
   // Pads
   input wire logic [PORT_A_PADS-1:0] PAD_A_IN,
   input wire logic [PORT_B_PADS-1:0] PAD_B_IN,
   output logic [PORT_A_PADS-1:0] PAD_A_OUT,
   output logic [PORT_A_PADS-1:0] PAD_A_OE,
   output logic [PORT_B_PADS-1:0] PAD_B_OUT,
   output logic [PORT_B_PADS-1:0] PAD_B_OE,
   // Peripheral signals
   input wire logic [SIG_COUNT-1:0] PERIPH_OUT,
   input wire logic [SIG_COUNT-1:0] PERIPH_OE,
   output logic [SIG_COUNT-1:0] PERIPH_IN,
   // Clock control
   output logic CLOCK_OUT_PIN,
   output logic TIMER_RATE_SELECT,
   output logic PWM_RATE_SELECT,
   output scs_clk_gate_t PERIPH_CLK_EN
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions
   // Which peripheral signal a pad carries in peripheral mode
   function automatic int pad_sig(input int pad, input logic [REG_W-1:0] gps);
      logic b_alt;
      logic [1:0] a_fn;
      b_alt = 1'b0;
      a_fn = 2'h0;
      pad_sig = SIG_PIN_A0_CLOCK_SELECT;
      if (pad >= PORT_A_PADS)
      begin
         b_alt = gps[GPS_B_LSB + pad - PORT_A_PADS];
      end
      case (pad)
         4:
         begin
            a_fn = gps[GPS_A4_LSB +: 2];
            pad_sig = (a_fn == A_FN_FAULT) ? SIG_PWM_FAULT_INPUT_1 : (a_fn == A_FN_TIMER) ? SIG_T2 : SIG_PWM4; // RULE18
         end
         5:
         begin
            a_fn = gps[GPS_A5_LSB +: 2];
            pad_sig = (a_fn == A_FN_FAULT) ? SIG_PWM_FAULT_INPUT_2 : (a_fn == A_FN_TIMER) ? SIG_T3 : SIG_PWM5; // RULE17
         end
         6: pad_sig = b_alt ? SIG_SCL : SIG_SCLK; // RULE16
         7: pad_sig = b_alt ? SIG_SDA : SIG_SS; // RULE16
         8: pad_sig = b_alt ? SIG_T2 : SIG_MISO; // RULE15
         9: pad_sig = b_alt ? SIG_T3 : SIG_MOSI; // RULE15
         10: pad_sig = b_alt ? SIG_CLOCK_OUT_PIN : SIG_T0; // RULE14
         11: pad_sig = b_alt ? SIG_PWM_FAULT_INPUT_3 : SIG_T1; // RULE14
         12: pad_sig = b_alt ? SIG_SDA : SIG_RXD; // RULE13
         13: pad_sig = b_alt ? SIG_SCL : SIG_TXD; // RULE13
         default: pad_sig = SIG_PIN_A0_CLOCK_SELECT + pad; // RULE1
      endcase
   endfunction

   // Clock-out source; unlisted codes give a quiet low
   function automatic logic clk_mux(input logic [CO_SRC_W-1:0] sel, input scs_clk_src_t src);
      case (sel) // RULE5
         SRC_SYS: clk_mux = src.sys;
         SRC_MASTER_OSCILLATOR_CLOCK: clk_mux = src.master_oscillator_clock;
         SRC_ADC: clk_mux = src.adc;
         SRC_TCK: clk_mux = src.tck;
         SRC_PER: clk_mux = src.per;
         SRC_PER_INV: clk_mux = ~src.per;
         SRC_HS_PER: clk_mux = src.hs_per;
         default: clk_mux = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for pads and clock sources
   scs_clk_src_t clk_sync1_reg, clk_sync2_reg, clk_sync1_next, clk_sync2_next;
   logic [NUM_PADS-1:0] pad_sync1_reg, pad_sync2_reg, pad_sync1_next, pad_sync2_next;

   always_comb
   begin
      clk_sync1_next = CLK_SRC;
      clk_sync2_next = clk_sync1_reg;
      pad_sync1_next = {PAD_B_IN, PAD_A_IN};
      pad_sync2_next = pad_sync1_reg;
   end
   // No reset: pure sampling stages, settle within two edges
   always_ff @(posedge REF_CLK)
   begin
      clk_sync1_reg <= clk_sync1_next;
      clk_sync2_reg <= clk_sync2_next;
      pad_sync1_reg <= pad_sync1_next;
      pad_sync2_reg <= pad_sync2_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and APB slave
   logic [REG_W-1:0] clk_out_reg, clk_out_next;
   logic [REG_W-1:0] gps_reg, gps_next;
   logic [REG_W-1:0] pce_reg, pce_next;
   logic [DATA_W-1:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic apb_setup, apb_write;
   assign apb_setup = PSEL && !PENABLE;
   assign apb_write = PSEL && PENABLE && PWRITE && pready_reg;
   always_comb
   begin
      clk_out_next = clk_out_reg;
      gps_next = gps_reg;
      pce_next = pce_reg;
      prdata_next = prdata_reg;
      pslverr_next = pslverr_reg;
      pready_next = 1'b1;
      if (apb_write)
      begin
         case (PADDR) // RULE22
            ADDR_CLOCK_OUT_SELECT: clk_out_next = PWDATA[REG_W-1:0] & CO_MASK;
            ADDR_PIN_FUNCTION_SELECT: gps_next = PWDATA[REG_W-1:0] & GPS_MASK;
            ADDR_PERIPHERAL_CLOCK_GATE: pce_next = PWDATA[REG_W-1:0] & PCE_MASK;
            default: clk_out_next = clk_out_reg;
         endcase
      end
      // Read data and error are fixed in the setup cycle, so the access is zero-wait
      if (apb_setup)
      begin
         pslverr_next = 1'b0;
         case (PADDR)
            ADDR_CLOCK_OUT_SELECT: prdata_next = {{(DATA_W-REG_W){1'b0}}, clk_out_reg & CO_MASK};
            ADDR_PIN_FUNCTION_SELECT: prdata_next = {{(DATA_W-REG_W){1'b0}}, gps_reg & GPS_MASK};
            ADDR_PERIPHERAL_CLOCK_GATE: prdata_next = {{(DATA_W-REG_W){1'b0}}, pce_reg & PCE_MASK};
            default:
            begin
               prdata_next = '0;
               pslverr_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         clk_out_reg <= CO_RESET; // RULE3
         gps_reg <= GPS_RESET;
         pce_reg <= PCE_RESET;
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         clk_out_reg <= clk_out_next;
         gps_reg <= gps_next;
         pce_reg <= pce_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pad routing, clock-out and clock control outputs
   logic [NUM_PADS-1:0] per_en_all;
   logic [CLK_PADS-1:0] pad_clk;
   logic [NUM_PADS-1:0] pad_out_reg, pad_out_next, pad_oe_reg, pad_oe_next;
   logic [SIG_COUNT-1:0] periph_in_reg, periph_in_next;
   logic clock_out_pin_reg, clock_out_pin_next;
   logic timer_rate_reg, timer_rate_next, pwm_rate_reg, pwm_rate_next;
   scs_clk_gate_t clk_gate_reg, clk_gate_next;

   assign per_en_all = {PORT_B_PERIPHERAL_ENABLE, PORT_A_PERIPHERAL_ENABLE};
   assign pad_clk = {clk_sync2_reg.relax, clk_sync2_reg.sys, clk_sync2_reg.sys2x, clk_sync2_reg.sys3x};
   always_comb
   begin
      int sig;
      sig = 0;
      pad_out_next = '0;
      pad_oe_next = '0;
      periph_in_next = '0;
      for (int p = 0; p < NUM_PADS; p++)
      begin
         sig = pad_sig(p, gps_reg);
         pad_out_next[p] = PERIPH_OUT[sig];
         pad_oe_next[p] = PERIPH_OE[sig];
         if (sig == SIG_CLOCK_OUT_PIN)
         begin
            pad_out_next[p] = clock_out_pin_reg; // RULE14
            pad_oe_next[p] = 1'b1;
         end
         if (p < CLK_PADS && clk_out_reg[CO_PADSEL_LSB + p])
         begin
            pad_out_next[p] = pad_clk[p]; // RULE1
            pad_oe_next[p] = 1'b1;
         end
         // GPIO owns the pad unless its peripheral enable is set
         if (!per_en_all[p])
         begin
            pad_out_next[p] = 1'b0; // RULE2 RULE7
            pad_oe_next[p] = 1'b0;
         end
         else
         begin
            periph_in_next[sig] = periph_in_next[sig] | pad_sync2_reg[p]; // RULE19
         end
      end
      // Sampled on REF_CLK: latency and glitches are tolerated here
      clock_out_pin_next = clk_out_reg[CO_DIS_BIT] ? 1'b0 : clk_mux(clk_out_reg[CO_SRC_LSB +: CO_SRC_W], clk_sync2_reg); // RULE4 RULE6
      timer_rate_next = gps_reg[GPS_TCR_BIT]; // RULE8 RULE23
      pwm_rate_next = gps_reg[GPS_PCR_BIT]; // RULE9
      clk_gate_next.i2c = pce_reg[PCE_I2C_BIT]; // RULE20
      clk_gate_next.adc = pce_reg[PCE_ADC_BIT];
      clk_gate_next.tmr = pce_reg[PCE_TMR_BIT];
      clk_gate_next.serial_port_clock_enable = pce_reg[PCE_SCI_BIT];
      clk_gate_next.spi = pce_reg[PCE_SPI_BIT];
      clk_gate_next.pwm = pce_reg[PCE_PWM_BIT];
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         pad_out_reg <= '0;
         pad_oe_reg <= '0;
         periph_in_reg <= '0;
         clock_out_pin_reg <= 1'b0;
         timer_rate_reg <= 1'b0;
         pwm_rate_reg <= 1'b0;
         clk_gate_reg <= '0;
      end
      else
      begin
         pad_out_reg <= pad_out_next;
         pad_oe_reg <= pad_oe_next;
         periph_in_reg <= periph_in_next;
         clock_out_pin_reg <= clock_out_pin_next;
         timer_rate_reg <= timer_rate_next;
         pwm_rate_reg <= pwm_rate_next;
         clk_gate_reg <= clk_gate_next;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign PAD_A_OUT = pad_out_reg[PORT_A_PADS-1:0];
   assign PAD_A_OE = pad_oe_reg[PORT_A_PADS-1:0];
   assign PAD_B_OUT = pad_out_reg[NUM_PADS-1:PORT_A_PADS];
   assign PAD_B_OE = pad_oe_reg[NUM_PADS-1:PORT_A_PADS];
   assign PERIPH_IN = periph_in_reg;
   assign CLOCK_OUT_PIN = clock_out_pin_reg;
   assign TIMER_RATE_SELECT = timer_rate_reg;
   assign PWM_RATE_SELECT = pwm_rate_reg;
   assign PERIPH_CLK_EN = clk_gate_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_gps_write;
      PSEL && PENABLE && PWRITE && PADDR == ADDR_PIN_FUNCTION_SELECT;
   endsequence
   sequence s_pce_write;
      PSEL && PENABLE && PWRITE && PADDR == ADDR_PERIPHERAL_CLOCK_GATE;
   endsequence
   sequence s_sys_selected;
      !clk_out_reg[CO_DIS_BIT] && clk_out_reg[CO_SRC_LSB +: CO_SRC_W] == SRC_SYS;
   endsequence
   sequence s_per_inv_selected;
      !clk_out_reg[CO_DIS_BIT] && clk_out_reg[CO_SRC_LSB +: CO_SRC_W] == SRC_PER_INV;
   endsequence
   chk_pwm_default_path: assert property ( // RULE1
      (PORT_A_PERIPHERAL_ENABLE[0] && !clk_out_reg[CO_PADSEL_LSB])
      |=> PAD_A_OUT[0] == $past(PERIPH_OUT[SIG_PIN_A0_CLOCK_SELECT]) && PAD_A_OE[0] == $past(PERIPH_OE[SIG_PIN_A0_CLOCK_SELECT]))
      else $error("pad A0 does not carry PIN_A0_CLOCK_SELECT");
   chk_pad_clock_path: assert property ( // RULE1
      (PORT_A_PERIPHERAL_ENABLE[3] && clk_out_reg[CO_PADSEL_LSB + 3])
      |=> PAD_A_OE[3] && PAD_A_OUT[3] == $past(clk_sync2_reg.relax))
      else $error("pad A3 does not carry oscillator clock");
   chk_gpio_priority: assert property ( // RULE7
      !PORT_A_PERIPHERAL_ENABLE[2] |=> !PAD_A_OE[2] && !PAD_A_OUT[2])
      else $error("pad A2 driven while GPIO owns it");
   chk_reset_values: assert property ( // RULE3
      $rose(RST_N) |-> clk_out_reg == CO_RESET && gps_reg == GPS_RESET && pce_reg == PCE_RESET)
      else $error("register not at reset value after reset");
   chk_clkout_disable: assert property ( // RULE4
      clk_out_reg[CO_DIS_BIT] |=> !CLOCK_OUT_PIN)
      else $error("clock-out pin not low while disabled");
   chk_clkout_source: assert property ( // RULE5
      s_sys_selected |=> CLOCK_OUT_PIN == $past(clk_sync2_reg.sys))
      else $error("clock-out does not follow system clock");
   chk_clkout_inverted: assert property ( // RULE5
      s_per_inv_selected |=> CLOCK_OUT_PIN == !$past(clk_sync2_reg.per))
      else $error("clock-out does not follow inverted peripheral clock");
   chk_rate_follow: assert property ( // RULE8
      s_gps_write |=> ##1 TIMER_RATE_SELECT == $past(PWDATA[GPS_TCR_BIT], 2)
      && PWM_RATE_SELECT == $past(PWDATA[GPS_PCR_BIT], 2))
      else $error("rate selects do not follow write");
   chk_b4_clock_out: assert property ( // RULE14
      (PORT_B_PERIPHERAL_ENABLE[4] && gps_reg[GPS_B_LSB + 4])
      |=> PAD_B_OE[4] && PAD_B_OUT[4] == $past(clock_out_pin_reg))
      else $error("pad B4 does not carry clock-out");
   chk_b3_spi_path: assert property ( // RULE15
      (PORT_B_PERIPHERAL_ENABLE[3] && !gps_reg[GPS_B_LSB + 3])
      |=> PAD_B_OUT[3] == $past(PERIPH_OUT[SIG_MOSI]))
      else $error("pad B3 does not carry MOSI");
   chk_a5_timer_path: assert property ( // RULE17
      (PORT_A_PERIPHERAL_ENABLE[5] && gps_reg[GPS_A5_LSB +: 2] == A_FN_TIMER)
      |=> PAD_A_OUT[5] == $past(PERIPH_OUT[SIG_T3]) && PAD_A_OE[5] == $past(PERIPH_OE[SIG_T3]))
      else $error("pad A5 does not carry timer 3");
   chk_input_or: assert property ( // RULE19
      (PORT_B_PERIPHERAL_ENABLE[0] && PORT_B_PERIPHERAL_ENABLE[7] && gps_reg[GPS_B_LSB] && gps_reg[GPS_B_LSB + 7])
      |=> PERIPH_IN[SIG_SCL] == $past(pad_sync2_reg[PORT_A_PADS] | pad_sync2_reg[PORT_A_PADS + 7]))
      else $error("shared I2C clock input not ORed");
   chk_clock_gate: assert property ( // RULE20
      s_pce_write |=> ##1 PERIPH_CLK_EN.i2c == $past(PWDATA[PCE_I2C_BIT], 2)
      && PERIPH_CLK_EN.pwm == $past(PWDATA[PCE_PWM_BIT], 2))
      else $error("clock gates do not follow write");
   chk_reserved_zero: assert property ( // RULE22
      (PSEL && !PENABLE && PADDR == ADDR_PERIPHERAL_CLOCK_GATE) |=> (PRDATA & ~DATA_W'(PCE_MASK)) == '0
      && (pce_reg & ~PCE_MASK) == '0)
      else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// >>> testbench/scs_pad_model.sv
// Pad wire model joining the block's pad drive to the board levels
`timescale 1ns/1ps
`default_nettype none
module scs_pad_model
   import scs_pkg::*;
(
   // Block side
   input wire logic [NUM_PADS-1:0] pad_out,
   input wire logic [NUM_PADS-1:0] pad_oe,
   // Board side
   input wire logic [NUM_PADS-1:0] ext_level,
   // Resolved pad levels
   output logic [NUM_PADS-1:0] pad_in
);
   // Board resistors hold every pad, so an undriven pad never floats
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule
`default_nettype wire

// >>> testbench/sim_pin_clock_select_test.sv
// Self-checking bench for the pin and clock select block
`timescale 1ns/1ps
`default_nettype none
module sim_pin_clock_select_test
   import scs_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready, pslverr, clock_out_pin, trs, prs;
   scs_clk_src_t clk_src = '0;
   logic [PORT_A_PADS-1:0] a_en = '0;
   logic [PORT_B_PADS-1:0] b_en = '0;
   logic [NUM_PADS-1:0] ext = '0;
   logic [NUM_PADS-1:0] pad_in;
   logic [PORT_A_PADS-1:0] a_out, a_oe;
   logic [PORT_B_PADS-1:0] b_out, b_oe;
   logic [SIG_COUNT-1:0] p_out = '0;
   logic [SIG_COUNT-1:0] p_oe = '0;
   logic [SIG_COUNT-1:0] p_in;
   scs_clk_gate_t gate;
   int n_fail = 0;
   int n_checks = 0;
   int bs [2][8] = '{'{SIG_SCLK, SIG_SS, SIG_MISO, SIG_MOSI, SIG_T0, SIG_T1, SIG_RXD, SIG_TXD},
                     '{SIG_SCL, SIG_SDA, SIG_T2, SIG_T3, SIG_CLOCK_OUT_PIN, SIG_PWM_FAULT_INPUT_3, SIG_SDA, SIG_SCL}};
   int gbit [6] = '{PCE_I2C_BIT, PCE_ADC_BIT, PCE_TMR_BIT, PCE_SCI_BIT, PCE_SPI_BIT, PCE_PWM_BIT};
   logic [CO_SRC_W-1:0] code [7] = '{SRC_SYS, SRC_MASTER_OSCILLATOR_CLOCK, SRC_ADC, SRC_TCK, SRC_PER, SRC_PER_INV, SRC_HS_PER};
   // Inverted source is probed with every other source high
   logic [8:0] pat [7] = '{9'h080, 9'h010, 9'h008, 9'h004, 9'h002, 9'h1fd, 9'h001};

   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   scs_pin_clock_select i_scs_pin_clock_select (
      .REF_CLK(ref_clk), .RST_N(rst_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CLK_SRC(clk_src),
      .PORT_A_PERIPHERAL_ENABLE(a_en), .PORT_B_PERIPHERAL_ENABLE(b_en),
      .PAD_A_IN(pad_in[5:0]), .PAD_B_IN(pad_in[13:6]),
      .PAD_A_OUT(a_out), .PAD_A_OE(a_oe), .PAD_B_OUT(b_out), .PAD_B_OE(b_oe),
      .PERIPH_OUT(p_out), .PERIPH_OE(p_oe), .PERIPH_IN(p_in),
      .CLOCK_OUT_PIN(clock_out_pin), .TIMER_RATE_SELECT(trs), .PWM_RATE_SELECT(prs), .PERIPH_CLK_EN(gate)
   );

   scs_pad_model i_scs_pad_model (
      .pad_out({b_out, a_out}), .pad_oe({b_oe, a_oe}), .ext_level(ext), .pad_in(pad_in)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (n_fail == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] rd, output logic err);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge ref_clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16)
      begin
         n_fail++;
         test_done();
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic eexp);
      logic [DATA_W-1:0] rd;
      logic err;
      apb(1'b0, a, '0, rd, err);
      chk(rd, exp);
      chk(32'(err), 32'(eexp));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int f;
      int p;
      int s;
      int b;
      logic [7:0] e;
      cyc(3);
      rst_n <= 1'b1;
      cyc(2);
      rdchk(ADDR_CLOCK_OUT_SELECT, 32'(CO_RESET), 1'b0);
      rdchk(ADDR_PIN_FUNCTION_SELECT, 32'(GPS_RESET), 1'b0);
      rdchk(ADDR_PERIPHERAL_CLOCK_GATE, 32'(PCE_RESET), 1'b0);
      chk(32'(clock_out_pin), 32'h0);
      // Both rates go to 3x together while all clocks are still gated
      wr(ADDR_PIN_FUNCTION_SELECT, 32'hffffffff);
      wr(ADDR_CLOCK_OUT_SELECT, 32'hffffffff);
      wr(ADDR_PERIPHERAL_CLOCK_GATE, 32'hffffffff);
      wr(8'h34, 32'hffffffff);
      rdchk(ADDR_CLOCK_OUT_SELECT, 32'(CO_MASK), 1'b0);
      rdchk(ADDR_PIN_FUNCTION_SELECT, 32'(GPS_MASK), 1'b0);
      rdchk(ADDR_PERIPHERAL_CLOCK_GATE, 32'(PCE_MASK), 1'b0);
      rdchk(8'h34, 32'h0, 1'b1);
      chk({30'h0, trs, prs}, 32'h3);
      for (p = 0; p < 6; p++)
      begin
         wr(ADDR_PERIPHERAL_CLOCK_GATE, 32'h1 << gbit[p]);
         cyc(2);
         chk(32'(gate), 32'h1 << (5 - p));
      end
      wr(ADDR_PERIPHERAL_CLOCK_GATE, 32'h0);
      // Timer alone at 3x tells the two rate bits apart
      wr(ADDR_PIN_FUNCTION_SELECT, 32'h8000);
      cyc(2);
      chk({30'h0, trs, prs}, 32'h2);
      wr(ADDR_PIN_FUNCTION_SELECT, 32'h0);
      cyc(2);
      chk({30'h0, trs, prs}, 32'h0);
      for (p = 0; p < 7; p++)
      begin
         clk_src <= pat[p];
         wr(ADDR_CLOCK_OUT_SELECT, 32'(code[p]));
         cyc(5);
         chk(32'(clock_out_pin), 32'h1);
         clk_src <= ~pat[p];
         cyc(5);
         chk(32'(clock_out_pin), 32'h0);
      end
      clk_src <= 9'h1ff;
      wr(ADDR_CLOCK_OUT_SELECT, 32'h20);
      cyc(5);
      chk(32'(clock_out_pin), 32'h0);
      a_en <= 6'h3f;
      p_oe <= '1;
      p_out <= '0;
      clk_src <= 9'h140;
      wr(ADDR_CLOCK_OUT_SELECT, 32'h3c0);
      cyc(5);
      chk(32'({a_oe[3:0], a_out[3:0]}), 32'hfa);
      clk_src <= 9'h0a0;
      cyc(5);
      chk(32'(a_out[3:0]), 32'h5);
      p_out <= 22'h6;
      wr(ADDR_CLOCK_OUT_SELECT, 32'h0);
      cyc(3);
      chk(32'({a_oe[3:0], a_out[3:0]}), 32'hf6);
      a_en <= 6'h30;
      cyc(3);
      chk(32'({a_oe[3:0], a_out[3:0]}), 32'h0);
      for (f = 0; f < 4; f++)
      begin
         wr(ADDR_PIN_FUNCTION_SELECT, 32'((f << 2) | f));
         b = (f < 2) ? SIG_PWM4 : (f == 2) ? SIG_PWM_FAULT_INPUT_1 : SIG_T2;
         for (p = 0; p < 2; p++)
         begin
            s = b + p;
            p_out <= 22'h1 << s;
            p_oe <= (f == 2) ? 22'h0 : 22'h1 << s;
            ext <= 14'h10 << p;
            cyc(5);
            if (f != 2)
               chk(32'(a_out[5:4]), 32'h1 << p);
            if (f >= 2)
               chk(32'(p_in[b +: 2]), 32'h1 << p);
         end
      end
      // Clock-out runs the system source, which is held high, so B4 shows a steady 1 while it carries clock-out
      wr(ADDR_CLOCK_OUT_SELECT, 32'(SRC_SYS));
      a_en <= '0;
      b_en <= 8'hff;
      for (f = 0; f < 2; f++)
      begin
         wr(ADDR_PIN_FUNCTION_SELECT, f ? 32'hff0 : 32'h0);
         for (p = 0; p < 8; p++)
         begin
            s = bs[f][p];
            for (b = 0; b < 8; b++)
               e[b] = (bs[f][b] == s) || (bs[f][b] == SIG_CLOCK_OUT_PIN);
            p_out <= 22'h1 << s;
            p_oe <= 22'h1 << s;
            ext <= '0;
            cyc(5);
            if (s != SIG_PWM_FAULT_INPUT_3 && s != SIG_RXD && s != SIG_CLOCK_OUT_PIN)
               chk(32'({b_oe, b_out}), 32'({e, e}));
            p_oe <= '0;
            ext <= 14'h40 << p;
            cyc(5);
            if (s != SIG_CLOCK_OUT_PIN)
               chk(32'(p_in[s]), 32'h1);
         end
      end
      b_en <= '0;
      p_oe <= '1;
      p_out <= '1;
      cyc(3);
      chk(32'({b_oe, b_out}), 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
